// ---- include/sslm_cfg.svh ----
// Constants of the twelve-stage shift-and-store LED sink block
`ifndef SSLM_CFG_SVH
`define SSLM_CFG_SVH

`define SSLM_STAGES 12
`define SSLM_FAST_TAP 10
`define SSLM_SLOW_TAP 11
`define SSLM_PIN_COUNT 4
`define SSLM_PIN_SHIFT_CLK 0
`define SSLM_PIN_SERIAL 1
`define SSLM_PIN_STROBE 2
`define SSLM_PIN_OUT_EN 3
`define SSLM_RST_BIT 1'h0
`define SSLM_RST_PINS 4'h0
`define SSLM_RST_STAGES 12'h000
`define SSLM_SINK_LEVEL 12'h000

`endif

// ---- include/sslm_pkg.sv ----
// Types shared by the shift-and-store LED sink modules
`include "sslm_cfg.svh"

package sslm_pkg;
    typedef logic [`SSLM_STAGES-1:0] sslm_stage_t;
    typedef logic [`SSLM_PIN_COUNT-1:0] sslm_pins_t;
    typedef enum logic [1:0] {
        SSLM_PH_UNKNOWN,
        SSLM_PH_LOW,
        SSLM_PH_HIGH
    } sslm_phase_t;
endpackage

// ---- include/sslm_link_if.sv ----
// Carrier between pin synchroniser, shift core and LED sink driver
`timescale 1ns/1ps
`include "sslm_cfg.svh"

interface sslm_link_if;
    logic shift_clk_s;
    logic serial_s;
    logic strobe_s;
    logic out_en_s;
    sslm_pkg::sslm_stage_t latch_q;

    modport sync_mp (
        output shift_clk_s,
        output serial_s,
        output strobe_s,
        output out_en_s
    );
    modport core_mp (
        input shift_clk_s,
        input serial_s,
        input strobe_s,
        output latch_q
    );
    modport drv_mp (
        input out_en_s,
        input latch_q
    );
endinterface

// ---- verilog/sslm_pin_sync.sv ----
// Two-flop synchroniser for the four host control pins
`timescale 1ns/1ps
`include "sslm_cfg.svh"

module sslm_pin_sync (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire sslm_pkg::sslm_pins_t i_pins,
    sslm_link_if.sync_mp link
);
    sslm_pkg::sslm_pins_t meta_ff;
    sslm_pkg::sslm_pins_t sync_ff;
    sslm_pkg::sslm_pins_t nxt_meta;
    sslm_pkg::sslm_pins_t nxt_sync;

    // All pins share one delay, so data stays aligned with the sampled clock
    always_comb begin
        nxt_meta = i_pins;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_ff <= `SSLM_RST_PINS;
            sync_ff <= `SSLM_RST_PINS;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign link.shift_clk_s = sync_ff[`SSLM_PIN_SHIFT_CLK];
    assign link.serial_s = sync_ff[`SSLM_PIN_SERIAL];
    assign link.strobe_s = sync_ff[`SSLM_PIN_STROBE];
    assign link.out_en_s = sync_ff[`SSLM_PIN_OUT_EN];
endmodule

// ---- verilog/sslm_led_drive.sv ----
// Open-drain LED sink stage: pull low for a stored one, float otherwise
`timescale 1ns/1ps
`include "sslm_cfg.svh"

module sslm_led_drive (
    input wire logic i_clk,
    input wire logic i_reset,
    sslm_link_if.drv_mp link,
    output sslm_pkg::sslm_stage_t o_sink_out,
    output sslm_pkg::sslm_stage_t o_sink_oe
);
    sslm_pkg::sslm_stage_t sink_oe_ff;
    sslm_pkg::sslm_stage_t nxt_sink_oe;
    sslm_pkg::sslm_stage_t sink_lvl_ff;
    sslm_pkg::sslm_stage_t nxt_sink_lvl;

    always_comb begin
        // Only a stored one with the enable high pulls the pin low
        nxt_sink_oe = link.out_en_s ? link.latch_q : `SSLM_RST_STAGES;
        // The pad never drives high: the off state is released, not driven
        nxt_sink_lvl = `SSLM_SINK_LEVEL;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sink_oe_ff <= `SSLM_RST_STAGES;
            sink_lvl_ff <= `SSLM_SINK_LEVEL;
        end else begin
            sink_oe_ff <= nxt_sink_oe;
            sink_lvl_ff <= nxt_sink_lvl;
        end
    end

    assign o_sink_out = sink_lvl_ff;
    assign o_sink_oe = sink_oe_ff;
endmodule

// ---- verilog/sslm_shift_store.sv ----
// Twelve-stage shift-and-store LED sink driver with two cascade outputs
`timescale 1ns/1ps
`include "sslm_cfg.svh"

module sslm_shift_store (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_SHIFT_CLK,
    input wire logic I_SERIAL_IN,
    input wire logic I_LATCH_STROBE,
    input wire logic I_OUT_ENABLE,
    input wire logic [`SSLM_STAGES-1:0] I_LED_SINK_IN,
    output logic [`SSLM_STAGES-1:0] O_LED_SINK_OUT,
    output logic [`SSLM_STAGES-1:0] O_LED_SINK_OE,
    output logic O_CASCADE_OUT_FAST,
    output logic O_CASCADE_OUT_SLOW
);
    sslm_link_if link ();

    sslm_pkg::sslm_pins_t pins;
    sslm_pkg::sslm_phase_t phase_ff;
    sslm_pkg::sslm_phase_t nxt_phase;
    sslm_pkg::sslm_stage_t stage_ff;
    sslm_pkg::sslm_stage_t nxt_stage;
    sslm_pkg::sslm_stage_t latch_ff;
    sslm_pkg::sslm_stage_t nxt_latch;
    logic fast_ff;
    logic nxt_fast;
    logic slow_ff;
    logic nxt_slow;
    logic clk_rise;
    logic clk_fall;
    logic stage_ten_prior;
    logic stage_eleven_prior;

    // A transition counts only from a level seen before, but the synchroniser resets low, so reset release
    // with the shift clock already high still fakes one rising edge once the high level is synchronised
    function automatic logic sslm_is_rise(input sslm_pkg::sslm_phase_t ph, input logic lvl);
        sslm_is_rise = (ph == sslm_pkg::SSLM_PH_LOW) && lvl;
    endfunction

    function automatic logic sslm_is_fall(input sslm_pkg::sslm_phase_t ph, input logic lvl);
        sslm_is_fall = (ph == sslm_pkg::SSLM_PH_HIGH) && !lvl;
    endfunction

    always_comb begin
        pins = `SSLM_RST_PINS;
        pins[`SSLM_PIN_SHIFT_CLK] = I_SHIFT_CLK;
        pins[`SSLM_PIN_SERIAL] = I_SERIAL_IN;
        pins[`SSLM_PIN_STROBE] = I_LATCH_STROBE;
        pins[`SSLM_PIN_OUT_EN] = I_OUT_ENABLE;
    end

    sslm_pin_sync u_sync (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_pins(pins),
        .link(link.sync_mp)
    );

    // Shift clock phase tracker
    always_comb begin
        case (phase_ff)
            sslm_pkg::SSLM_PH_UNKNOWN: begin
                nxt_phase = link.shift_clk_s ? sslm_pkg::SSLM_PH_HIGH : sslm_pkg::SSLM_PH_LOW;
            end
            sslm_pkg::SSLM_PH_LOW: begin
                nxt_phase = link.shift_clk_s ? sslm_pkg::SSLM_PH_HIGH : sslm_pkg::SSLM_PH_LOW;
            end
            sslm_pkg::SSLM_PH_HIGH: begin
                nxt_phase = link.shift_clk_s ? sslm_pkg::SSLM_PH_HIGH : sslm_pkg::SSLM_PH_LOW;
            end
            default: begin
                nxt_phase = sslm_pkg::SSLM_PH_UNKNOWN;
            end
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            phase_ff <= sslm_pkg::SSLM_PH_UNKNOWN;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    assign clk_rise = sslm_is_rise(phase_ff, link.shift_clk_s);
    assign clk_fall = sslm_is_fall(phase_ff, link.shift_clk_s);

    // Taps read before the edge updates the chain
    assign stage_ten_prior = stage_ff[`SSLM_FAST_TAP];
    assign stage_eleven_prior = stage_ff[`SSLM_SLOW_TAP];

    // Shift chain: bit 0 is the stage fed by the serial input
    always_comb begin
        nxt_stage = stage_ff;
        if (clk_rise) begin
            nxt_stage = {stage_ff[`SSLM_STAGES-2:0], link.serial_s};
        end
    end

    // Storage latches are transparent while the strobe is high; the copy lags
    // the chain by one system clock, which the host's idle-clock strobe hides
    always_comb begin
        nxt_latch = latch_ff;
        if (link.strobe_s) begin
            nxt_latch = stage_ff;
        end
    end

    // Cascade outputs
    always_comb begin
        nxt_fast = fast_ff;
        nxt_slow = slow_ff;
        if (clk_rise) begin
            nxt_fast = stage_ten_prior;
        end
        if (clk_fall) begin
            // After a rise the last stage holds the bit the fast tap took
            nxt_slow = stage_eleven_prior;
        end
    end

    // Reset is a simulation convenience; the chip itself powers up unknown
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            stage_ff <= `SSLM_RST_STAGES;
            latch_ff <= `SSLM_RST_STAGES;
            fast_ff <= `SSLM_RST_BIT;
            slow_ff <= `SSLM_RST_BIT;
        end else begin
            stage_ff <= nxt_stage;
            latch_ff <= nxt_latch;
            fast_ff <= nxt_fast;
            slow_ff <= nxt_slow;
        end
    end

    assign link.latch_q = latch_ff;

    // The pad readback I_LED_SINK_IN is not used by the core logic
    sslm_led_drive u_drive (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .link(link.drv_mp),
        .o_sink_out(O_LED_SINK_OUT),
        .o_sink_oe(O_LED_SINK_OE)
    );

    // Either tap may feed the next device's serial input
    assign O_CASCADE_OUT_FAST = fast_ff;
    assign O_CASCADE_OUT_SLOW = slow_ff;
endmodule

// ---- sim/sslm_host_model.sv ----
// Host controller model driving the shift, strobe and enable pins
`timescale 1ns/1ps

module sslm_host_model (
    input wire logic i_clk,
    output logic o_shift_clk,
    output logic o_serial,
    output logic o_strobe,
    output logic o_out_en
);
    initial begin
        o_shift_clk = 1'h0;
        o_serial = 1'h0;
        o_strobe = 1'h0;
        o_out_en = 1'h0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Data is flipped once its hold time has run out, so stale data is never seen
    task automatic shift_bit(input logic b, input int hi);
        o_serial = b;
        wait_n(3);
        o_shift_clk = 1'h1;
        wait_n(hi);
        o_shift_clk = 1'h0;
        wait_n(3);
        o_serial = ~b;
    endtask
    // Strobe only while the shift clock is idle low
    task automatic strobe_pulse();
        o_strobe = 1'h1;
        wait_n(4);
        o_strobe = 1'h0;
        wait_n(4);
    endtask
    task automatic set_enable(input logic e);
        o_out_en = e;
        wait_n(5);
    endtask
endmodule

// ---- sim/sslm_shift_store_asserts.sv ----
// Assertions on the LED sink pins and cascade outputs
`timescale 1ns/1ps

module sslm_shift_store_asserts (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_SHIFT_CLK,
    input wire logic I_LATCH_STROBE,
    input wire logic I_OUT_ENABLE,
    input wire sslm_pkg::sslm_stage_t O_LED_SINK_OUT,
    input wire sslm_pkg::sslm_stage_t O_LED_SINK_OE,
    input wire logic O_CASCADE_OUT_FAST,
    input wire logic O_CASCADE_OUT_SLOW
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    // Pin level two and three edges back covers the synchroniser lag
    sequence s_clk_was_high;
        $past(I_SHIFT_CLK, 2) && $past(I_SHIFT_CLK, 3);
    endsequence
    sequence s_clk_was_low;
        !$past(I_SHIFT_CLK, 2) && !$past(I_SHIFT_CLK, 3);
    endsequence
    a_reset_clears_all: assert property ($fell(I_RESET) |-> O_LED_SINK_OE == 12'h000
        && !O_CASCADE_OUT_FAST && !O_CASCADE_OUT_SLOW) else $error("outputs not clear after reset");
    a_sink_never_high: assert property (O_LED_SINK_OUT == 12'h000) else $error("LED pin driven high");
    a_disabled_floats: assert property ((!I_OUT_ENABLE)[*5] |-> O_LED_SINK_OE == 12'h000)
        else $error("LED pin sinks while disabled");
    a_sink_needs_enable: assert property (O_LED_SINK_OE != 12'h000
        |-> $past(I_OUT_ENABLE, 3) || $past(I_OUT_ENABLE, 4)) else $error("sink without enable");
    a_latch_holds: assert property ((!I_LATCH_STROBE && I_OUT_ENABLE)[*6]
        |=> $stable(O_LED_SINK_OE)) else $error("latch moved without strobe");
    a_fast_on_rise: assert property ($changed(O_CASCADE_OUT_FAST) |-> s_clk_was_high)
        else $error("fast cascade moved off a rise");
    a_slow_on_fall: assert property ($changed(O_CASCADE_OUT_SLOW) |-> s_clk_was_low)
        else $error("slow cascade moved off a fall");
    a_slow_repeats_fast: assert property ($changed(O_CASCADE_OUT_SLOW)
        |-> O_CASCADE_OUT_SLOW == O_CASCADE_OUT_FAST) else $error("slow cascade differs from fast");
endmodule

bind sslm_shift_store sslm_shift_store_asserts i_sslm_shift_store_asserts (
    .I_CLK(I_CLK), .I_RESET(I_RESET), .I_SHIFT_CLK(I_SHIFT_CLK), .I_LATCH_STROBE(I_LATCH_STROBE),
    .I_OUT_ENABLE(I_OUT_ENABLE), .O_LED_SINK_OUT(O_LED_SINK_OUT), .O_LED_SINK_OE(O_LED_SINK_OE),
    .O_CASCADE_OUT_FAST(O_CASCADE_OUT_FAST), .O_CASCADE_OUT_SLOW(O_CASCADE_OUT_SLOW)
);

// ---- sim/tb_top.sv ----
// Self-checking bench for the shift-and-store LED sink block
`timescale 1ns/1ps

module tb_top;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic sclk, sdat, stb, oen, fast, slow;
    sslm_pkg::sslm_stage_t pad, sink_out, sink_oe;
    int fail_count = 0;
    int checks = 0;
    always #50 clk = ~clk;
    // Pull-up on each LED pin: a released pin reads high
    assign pad = ~sink_oe;
    sslm_host_model i_sslm_host_model (.i_clk(clk), .o_shift_clk(sclk), .o_serial(sdat), .o_strobe(stb),
        .o_out_en(oen));
    sslm_shift_store i_sslm_shift_store (.I_CLK(clk), .I_RESET(rst), .I_SHIFT_CLK(sclk), .I_SERIAL_IN(sdat),
        .I_LATCH_STROBE(stb), .I_OUT_ENABLE(oen), .I_LED_SINK_IN(pad), .O_LED_SINK_OUT(sink_out),
        .O_LED_SINK_OE(sink_oe), .O_CASCADE_OUT_FAST(fast), .O_CASCADE_OUT_SLOW(slow));
    task automatic expect12(input sslm_pkg::sslm_stage_t got, input sslm_pkg::sslm_stage_t exp, input string what);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // First bit sent ends in the last stage, so send the top bit first
    task automatic load_word(input sslm_pkg::sslm_stage_t w, input int hi, input bit do_strobe);
        for (int i = 11; i >= 0; i--) begin
            i_sslm_host_model.shift_bit(w[i], hi);
        end
        if (do_strobe) begin
            i_sslm_host_model.strobe_pulse();
        end
    endtask
    task automatic test_reset();
        expect12(sink_oe, 12'h000, "oe after reset");
        expect12({10'h000, fast, slow}, 12'h000, "cascades after reset");
    endtask
    task automatic test_pattern(input sslm_pkg::sslm_stage_t w, input int hi);
        load_word(w, hi, 1'h1);
        i_sslm_host_model.set_enable(1'h1);
        expect12(sink_oe, w, "pattern");
        expect12(pad, ~w, "pin level");
        expect12(sink_out, 12'h000, "drive level");
    endtask
    task automatic test_hold_off(input sslm_pkg::sslm_stage_t w);
        test_pattern(w, 4);
        load_word(~w, 3, 1'h0);
        expect12(sink_oe, w, "hold without strobe");
        i_sslm_host_model.set_enable(1'h0);
        expect12(sink_oe, 12'h000, "disabled");
        i_sslm_host_model.set_enable(1'h1);
        expect12(sink_oe, w, "enable restores latch");
        i_sslm_host_model.strobe_pulse();
        expect12(sink_oe, ~w, "strobe loads chain");
    endtask
    task automatic test_cascade(input sslm_pkg::sslm_stage_t w);
        for (int k = 0; k < 2; k++) begin
            i_sslm_host_model.shift_bit(1'h0, 3);
            i_sslm_host_model.wait_n(3);
            expect12({11'h000, fast}, {11'h000, w[10-k]}, "fast cascade");
            expect12({11'h000, slow}, {11'h000, w[10-k]}, "slow cascade");
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst = 1'h0;
        i_sslm_host_model.wait_n(4);
        test_reset();
        test_pattern(12'ha5c, 6);
        test_pattern(12'h801, 3);
        test_hold_off(12'h3c6);
        test_cascade(12'hc39);
        report_and_stop();
    end
    initial begin
        #500000;
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule
